// ==== logic/port_pin_config_and_data.v ====
// Four general-purpose ports on the processor's special-function bus:
// pin direction registers for ports 2 and 3, port data registers with
// byte and single-bit access, and the alternate peripheral routing.
// Assumes one synchronous clock, pins already synchronous, and port 0 and
// port 1 directions supplied by configuration logic outside this block.
//
// Functional notes
// - Port2 bits 7,5,4 clear: peripheral inputs.
// - Port2 bit 6 set: output, data-out.
// - Port2 bits 3..0 set: outputs, chip selects.
// - Port3 bits 7,6 set: two-wire clock/data outputs.
// - Port3 bits 5,2 clear: timer count inputs.
// - Port3 bits 4,3 clear: capture inputs.
// - Port3 bit 1 clear: serial receive input.
// - Port3 bit 0 set: serial transmit output.
// - Four ports, bit-addressable data registers.
// - Port0/1 upper nibbles unpinned, read zero.
// - Output pin without an enabled alternate function shows last written data.
// - Input pin read returns pin level.
// - Data one drives high, zero low.
// - Port3 config at 9EH, data B0H.
// - Reset leaves every Port2/3 pin an input.
// - Port2 config decoded at 9DH.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_map.vh"

module port_pin_config_and_data #(
	parameter NARROW_W = `NARROW_PORT_W,
	parameter WIDE_W = `WIDE_PORT_W
) (
	input wire clk,
	input wire resetn,
	input wire [`REG_W-1:0] sfrAddr,
	input wire sfrWrite,
	input wire sfrRead,
	input wire [`REG_W-1:0] sfrWrData,
	output reg [`REG_W-1:0] sfrRdData,
	output wire sfrHit,
	input wire [`REG_W-1:0] bitAddr,
	input wire bitWrite,
	input wire bitRead,
	input wire bitWrData,
	output reg bitRdData,
	output wire bitHit,
	input wire [NARROW_W-1:0] port0OutSel,
	input wire [NARROW_W-1:0] port1OutSel,
	input wire [NARROW_W-1:0] p0PinIn,
	output wire [NARROW_W-1:0] p0PinOut,
	output wire [NARROW_W-1:0] p0PinOe,
	input wire [NARROW_W-1:0] p1PinIn,
	output wire [NARROW_W-1:0] p1PinOut,
	output wire [NARROW_W-1:0] p1PinOe,
	input wire [WIDE_W-1:0] p2PinIn,
	output wire [WIDE_W-1:0] p2PinOut,
	output wire [WIDE_W-1:0] p2PinOe,
	input wire [WIDE_W-1:0] p3PinIn,
	output wire [WIDE_W-1:0] p3PinOut,
	output wire [WIDE_W-1:0] p3PinOe,
	input wire spiEnable,
	input wire spiDataOut,
	input wire [`CS_W-1:0] spiChipSel,
	output reg spiDataIn,
	output reg spiClockIn,
	output reg spiSlaveSelIn,
	input wire twoWireEnable,
	input wire twoWireClockOut,
	input wire twoWireDataOut,
	input wire timerEnableA,
	input wire timerEnableB,
	output reg timerCountA,
	output reg timerCountB,
	output reg captureInputA,
	output reg captureInputB,
	input wire serial0Enable,
	input wire serial0TxData,
	output reg serial0RxData
);
	reg [`REG_W-1:0] port2Cfg_q;
	reg [`REG_W-1:0] port3Cfg_q;

	wire hitP0;
	wire hitP1;
	wire hitP2;
	wire hitP3;
	wire hitCfg2;
	wire hitCfg3;
	wire [`REG_W-1:0] bitByte;
	wire [`BIT_SEL_MSB:0] bitSel;
	wire bitP0;
	wire bitP1;
	wire bitP2;
	wire bitP3;
	wire [`REG_W-1:0] readP0;
	wire [`REG_W-1:0] readP1;
	wire [`REG_W-1:0] readP2;
	wire [`REG_W-1:0] readP3;
	wire [WIDE_W-1:0] p2Level;
	wire [WIDE_W-1:0] p3Level;
	wire [WIDE_W-1:0] p2AltEn;
	wire [WIDE_W-1:0] p2AltVal;
	wire [WIDE_W-1:0] p3AltEn;
	wire [WIDE_W-1:0] p3AltVal;
	reg [`REG_W-1:0] rdMux;
	reg [`REG_W-1:0] bitByteMux;

	// Byte address decode.
	assign hitP0 = (sfrAddr == `ADDR_PORT0_DATA);
	assign hitP1 = (sfrAddr == `ADDR_PORT1_DATA);
	assign hitP2 = (sfrAddr == `ADDR_PORT2_DATA);
	assign hitP3 = (sfrAddr == `ADDR_PORT3_DATA);
	assign hitCfg2 = (sfrAddr == `ADDR_PORT2_CFG);
	assign hitCfg3 = (sfrAddr == `ADDR_PORT3_CFG);
	assign sfrHit = hitP0 | hitP1 | hitP2 | hitP3 | hitCfg2 | hitCfg3;

	// Bit address decode: the bit space of each port sits on its byte address.
	assign bitByte = {bitAddr[`BIT_BYTE_MSB:`BIT_BYTE_LSB], {`BIT_BYTE_LSB{1'b0}}};
	assign bitSel = bitAddr[`BIT_SEL_MSB:0];
	assign bitP0 = (bitByte == `ADDR_PORT0_DATA);
	assign bitP1 = (bitByte == `ADDR_PORT1_DATA);
	assign bitP2 = (bitByte == `ADDR_PORT2_DATA);
	assign bitP3 = (bitByte == `ADDR_PORT3_DATA);
	assign bitHit = bitP0 | bitP1 | bitP2 | bitP3;

	// Configuration registers. Zero everywhere means every pin is an input.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			port2Cfg_q <= `CFG_RESET;
			port3Cfg_q <= `CFG_RESET;
		end else if (sfrWrite) begin
			if (hitCfg2) begin
				port2Cfg_q <= sfrWrData;
			end
			if (hitCfg3) begin
				port3Cfg_q <= sfrWrData;
			end
		end
	end

	// Port 2 alternate outputs: data-out on bit 6, chip selects on bits 3..0.
	// Input-side bits carry no alternate output, so the latch drives them when set.
	assign p2AltEn[`P2_SERIAL_IN] = 1'b0;
	assign p2AltEn[`P2_SERIAL_OUT] = spiEnable;
	assign p2AltEn[`P2_SERIAL_CLOCK] = 1'b0;
	assign p2AltEn[`P2_SLAVE_SELECT] = 1'b0;
	assign p2AltEn[`P2_CS_MSB:`P2_CS_LSB] = {`CS_W{spiEnable}};
	assign p2AltVal[`P2_SERIAL_IN] = 1'b0;
	assign p2AltVal[`P2_SERIAL_OUT] = spiDataOut;
	assign p2AltVal[`P2_SERIAL_CLOCK] = 1'b0;
	assign p2AltVal[`P2_SLAVE_SELECT] = 1'b0;
	// Chip select bit 0 sits on pin 3, bit 3 on pin 0.
	assign p2AltVal[`P2_CS_MSB] = spiChipSel[0];
	assign p2AltVal[`P2_CS_MSB-1] = spiChipSel[1];
	assign p2AltVal[`P2_CS_LSB+1] = spiChipSel[2];
	assign p2AltVal[`P2_CS_LSB] = spiChipSel[3];

	// Port 3 alternate outputs: two-wire clock and data, serial transmit.
	assign p3AltEn[`P3_TWOWIRE_CLOCK] = twoWireEnable;
	assign p3AltEn[`P3_TWOWIRE_DATA] = twoWireEnable;
	assign p3AltEn[`P3_TIMER_B] = 1'b0;
	assign p3AltEn[`P3_CAPTURE_B] = 1'b0;
	assign p3AltEn[`P3_CAPTURE_A] = 1'b0;
	assign p3AltEn[`P3_TIMER_A] = 1'b0;
	assign p3AltEn[`P3_SERIAL0_RX] = 1'b0;
	assign p3AltEn[`P3_SERIAL0_TX] = serial0Enable;
	assign p3AltVal[`P3_TWOWIRE_CLOCK] = twoWireClockOut;
	assign p3AltVal[`P3_TWOWIRE_DATA] = twoWireDataOut;
	assign p3AltVal[`P3_TIMER_B] = 1'b0;
	assign p3AltVal[`P3_CAPTURE_B] = 1'b0;
	assign p3AltVal[`P3_CAPTURE_A] = 1'b0;
	assign p3AltVal[`P3_TIMER_A] = 1'b0;
	assign p3AltVal[`P3_SERIAL0_RX] = 1'b0;
	assign p3AltVal[`P3_SERIAL0_TX] = serial0TxData;

	gpio_port_slice #(
		.PIN_W(NARROW_W)
	) port0 (
		.clk(clk),
		.resetn(resetn),
		.byteWrite(sfrWrite & hitP0),
		.bitWrite(bitWrite & bitP0),
		.bitSel(bitSel),
		.wrData(sfrWrData),
		.bitWrData(bitWrData),
		.dirOut(port0OutSel),
		.altEn({NARROW_W{1'b0}}),
		.altVal({NARROW_W{1'b0}}),
		.pinIn(p0PinIn),
		.pinOut(p0PinOut),
		.pinOe(p0PinOe),
		.pinLevel(),
		.readValue(readP0)
	);

	gpio_port_slice #(
		.PIN_W(NARROW_W)
	) port1 (
		.clk(clk),
		.resetn(resetn),
		.byteWrite(sfrWrite & hitP1),
		.bitWrite(bitWrite & bitP1),
		.bitSel(bitSel),
		.wrData(sfrWrData),
		.bitWrData(bitWrData),
		.dirOut(port1OutSel),
		.altEn({NARROW_W{1'b0}}),
		.altVal({NARROW_W{1'b0}}),
		.pinIn(p1PinIn),
		.pinOut(p1PinOut),
		.pinOe(p1PinOe),
		.pinLevel(),
		.readValue(readP1)
	);

	gpio_port_slice #(
		.PIN_W(WIDE_W)
	) port2 (
		.clk(clk),
		.resetn(resetn),
		.byteWrite(sfrWrite & hitP2),
		.bitWrite(bitWrite & bitP2),
		.bitSel(bitSel),
		.wrData(sfrWrData),
		.bitWrData(bitWrData),
		.dirOut(port2Cfg_q[WIDE_W-1:0]),
		.altEn(p2AltEn),
		.altVal(p2AltVal),
		.pinIn(p2PinIn),
		.pinOut(p2PinOut),
		.pinOe(p2PinOe),
		.pinLevel(p2Level),
		.readValue(readP2)
	);

	gpio_port_slice #(
		.PIN_W(WIDE_W)
	) port3 (
		.clk(clk),
		.resetn(resetn),
		.byteWrite(sfrWrite & hitP3),
		.bitWrite(bitWrite & bitP3),
		.bitSel(bitSel),
		.wrData(sfrWrData),
		.bitWrData(bitWrData),
		.dirOut(port3Cfg_q[WIDE_W-1:0]),
		.altEn(p3AltEn),
		.altVal(p3AltVal),
		.pinIn(p3PinIn),
		.pinOut(p3PinOut),
		.pinOe(p3PinOe),
		.pinLevel(p3Level),
		.readValue(readP3)
	);

	// Peripheral input feeds. A pin set to output no longer feeds its peripheral,
	// which then sees the idle high that the pull-up would give.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			spiDataIn <= `FEED_IDLE;
			spiClockIn <= `FEED_IDLE;
			spiSlaveSelIn <= `FEED_IDLE;
			timerCountA <= `FEED_IDLE;
			timerCountB <= `FEED_IDLE;
			captureInputA <= `FEED_IDLE;
			captureInputB <= `FEED_IDLE;
			serial0RxData <= `FEED_IDLE;
		end else begin
			spiDataIn <= port2Cfg_q[`P2_SERIAL_IN] ? `FEED_IDLE : p2Level[`P2_SERIAL_IN];
			spiClockIn <= port2Cfg_q[`P2_SERIAL_CLOCK] ? `FEED_IDLE : p2Level[`P2_SERIAL_CLOCK];
			spiSlaveSelIn <= port2Cfg_q[`P2_SLAVE_SELECT] ? `FEED_IDLE : p2Level[`P2_SLAVE_SELECT];
			timerCountA <= (!timerEnableA || port3Cfg_q[`P3_TIMER_A]) ? `FEED_IDLE : p3Level[`P3_TIMER_A];
			timerCountB <= (!timerEnableB || port3Cfg_q[`P3_TIMER_B]) ? `FEED_IDLE : p3Level[`P3_TIMER_B];
			captureInputA <= port3Cfg_q[`P3_CAPTURE_A] ? `FEED_IDLE : p3Level[`P3_CAPTURE_A];
			captureInputB <= port3Cfg_q[`P3_CAPTURE_B] ? `FEED_IDLE : p3Level[`P3_CAPTURE_B];
			serial0RxData <= port3Cfg_q[`P3_SERIAL0_RX] ? `FEED_IDLE : p3Level[`P3_SERIAL0_RX];
		end
	end

	// Byte read multiplexer; unmapped addresses read zero.
	always @* begin
		rdMux = `READ_RESET;
		case (1'b1)
			hitP0: rdMux = readP0;
			hitP1: rdMux = readP1;
			hitP2: rdMux = readP2;
			hitP3: rdMux = readP3;
			hitCfg2: rdMux = port2Cfg_q;
			hitCfg3: rdMux = port3Cfg_q;
			default: rdMux = `READ_RESET;
		endcase
	end

	always @* begin
		bitByteMux = `READ_RESET;
		case (1'b1)
			bitP0: bitByteMux = readP0;
			bitP1: bitByteMux = readP1;
			bitP2: bitByteMux = readP2;
			bitP3: bitByteMux = readP3;
			default: bitByteMux = `READ_RESET;
		endcase
	end

	// Read data are held until the next read so the processor may sample late.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sfrRdData <= `READ_RESET;
			bitRdData <= 1'b0;
		end else begin
			if (sfrRead) begin
				sfrRdData <= rdMux;
			end
			if (bitRead) begin
				bitRdData <= bitByteMux[bitSel];
			end
		end
	end
endmodule // port_pin_config_and_data

`default_nettype wire

// ==== logic/gpio_port_map.vh ====
// Constants for the four-port general-purpose pin block: register addresses,
// field positions, reset values and port widths.
// Assumes it is included by bare name from the design files of this block.
`ifndef GPIO_PORT_MAP_VH
`define GPIO_PORT_MAP_VH

// Special-function register byte addresses.
`define ADDR_PORT0_DATA 8'h80
`define ADDR_PORT1_DATA 8'h90
`define ADDR_PORT2_CFG 8'h9d
`define ADDR_PORT3_CFG 8'h9e
`define ADDR_PORT2_DATA 8'ha0
`define ADDR_PORT3_DATA 8'hb0

// Bit addresses: the upper five bits name the byte, the lower three the bit.
`define BIT_BYTE_MSB 7
`define BIT_BYTE_LSB 3
`define BIT_SEL_MSB 2

// Widths.
`define REG_W 8
`define NARROW_PORT_W 4
`define WIDE_PORT_W 8
`define CS_W 4

// Reset values.
`define CFG_RESET 8'h00
`define DATA_RESET 8'hff
`define READ_RESET 8'h00
`define FEED_IDLE 1'b1

// Port 2 configuration fields.
`define P2_SERIAL_IN 7
`define P2_SERIAL_OUT 6
`define P2_SERIAL_CLOCK 5
`define P2_SLAVE_SELECT 4
`define P2_CS_MSB 3
`define P2_CS_LSB 0

// Port 3 configuration fields.
`define P3_TWOWIRE_CLOCK 7
`define P3_TWOWIRE_DATA 6
`define P3_TIMER_B 5
`define P3_CAPTURE_B 4
`define P3_CAPTURE_A 3
`define P3_TIMER_A 2
`define P3_SERIAL0_RX 1
`define P3_SERIAL0_TX 0

`endif

// ==== logic/gpio_port_slice.v ====
// One port: its data latch with byte and single-bit writes, the pin driver
// and the read value. Assumes direction and alternate-function controls come
// from the parent, all on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_map.vh"

module gpio_port_slice #(
	parameter PIN_W = 8
) (
	input wire clk,
	input wire resetn,
	input wire byteWrite,
	input wire bitWrite,
	input wire [`BIT_SEL_MSB:0] bitSel,
	input wire [`REG_W-1:0] wrData,
	input wire bitWrData,
	input wire [PIN_W-1:0] dirOut,
	input wire [PIN_W-1:0] altEn,
	input wire [PIN_W-1:0] altVal,
	input wire [PIN_W-1:0] pinIn,
	output reg [PIN_W-1:0] pinOut,
	output reg [PIN_W-1:0] pinOe,
	output wire [PIN_W-1:0] pinLevel,
	output wire [`REG_W-1:0] readValue
);
	reg [`REG_W-1:0] latch_q;
	reg [PIN_W-1:0] sample_q;
	reg [`REG_W-1:0] readMix;
	integer i;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			latch_q <= `DATA_RESET;
		end else if (byteWrite) begin
			latch_q <= wrData;
		end else if (bitWrite) begin
			latch_q[bitSel] <= bitWrData;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sample_q <= {PIN_W{1'b0}};
			pinOut <= {PIN_W{1'b0}};
			pinOe <= {PIN_W{1'b0}};
		end else begin
			sample_q <= pinIn;
			// Alternate function wins over the latch only while its peripheral is on.
			pinOut <= (altEn & altVal) | (~altEn & latch_q[PIN_W-1:0]);
			pinOe <= dirOut;
		end
	end

	assign pinLevel = sample_q;

	// Unpinned upper bits read as zero so no stale latch looks like a level.
	always @* begin
		readMix = {`REG_W{1'b0}};
		for (i = 0; i < PIN_W; i = i + 1) begin
			readMix[i] = dirOut[i] ? latch_q[i] : sample_q[i];
		end
	end

	assign readValue = readMix;
endmodule // gpio_port_slice

`default_nettype wire

// ==== verif/port_pin_monitor.sv ====
// Checker for the four-port pin block, seeing only its top-level ports.
// Assumes the block's register map header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_map.vh"
module port_pin_monitor #(
	parameter NARROW_W = 4,
	parameter WIDE_W = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrite,
	input wire logic sfrRead,
	input wire logic [7:0] sfrWrData,
	input wire logic [7:0] sfrRdData,
	input wire logic sfrHit,
	input wire logic [7:0] bitAddr,
	input wire logic bitWrite,
	input wire logic bitWrData,
	input wire logic [WIDE_W-1:0] p2PinOut,
	input wire logic [WIDE_W-1:0] p2PinOe,
	input wire logic [WIDE_W-1:0] p3PinOut,
	input wire logic [WIDE_W-1:0] p3PinOe,
	input wire logic spiEnable,
	input wire logic twoWireEnable,
	input wire logic serial0Enable,
	input wire logic serial0RxData
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Pin enables lag a direction write by the configuration register and the pin flop.
	property p_p2_dir; sfrWrite && sfrAddr == `ADDR_PORT2_CFG |-> ##2 p2PinOe == $past(sfrWrData, 2); endproperty
	a_p2_dir: assert property (p_p2_dir) else $error("p2 enable mismatch");
	property p_p3_dir; sfrWrite && sfrAddr == `ADDR_PORT3_CFG |-> ##2 p3PinOe == $past(sfrWrData, 2); endproperty
	a_p3_dir: assert property (p_p3_dir) else $error("p3 enable mismatch");
	property p_p2_out;
		sfrWrite && sfrAddr == `ADDR_PORT2_DATA ##1 !spiEnable |=> (p2PinOut & p2PinOe) == ($past(sfrWrData, 2) & p2PinOe);
	endproperty
	a_p2_out: assert property (p_p2_out) else $error("p2 drive mismatch");
	property p_p3_out;
		sfrWrite && sfrAddr == `ADDR_PORT3_DATA ##1 !twoWireEnable && !serial0Enable
			|=> (p3PinOut & p3PinOe) == ($past(sfrWrData, 2) & p3PinOe);
	endproperty
	a_p3_out: assert property (p_p3_out) else $error("p3 drive mismatch");
	property p_bit_wr;
		bitWrite && bitAddr[7:3] == 5'h16 && !sfrWrite ##1 !twoWireEnable && !serial0Enable && p3PinOe == 8'hff
			|=> p3PinOut[$past(bitAddr[2:0], 2)] == $past(bitWrData, 2);
	endproperty
	a_bit_wr: assert property (p_bit_wr) else $error("bit write mismatch");
	property p_unmapped; sfrRead && !sfrHit |=> sfrRdData == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_hit;
		sfrHit == (sfrAddr inside {`ADDR_PORT0_DATA, `ADDR_PORT1_DATA, `ADDR_PORT2_CFG, `ADDR_PORT3_CFG,
			`ADDR_PORT2_DATA, `ADDR_PORT3_DATA});
	endproperty
	a_hit: assert property (p_hit) else $error("address decode mismatch");
	property p_nibble;
		sfrRead && (sfrAddr == `ADDR_PORT0_DATA || sfrAddr == `ADDR_PORT1_DATA) |=> sfrRdData[7:4] == 4'h0;
	endproperty
	a_nibble: assert property (p_nibble) else $error("unpinned bits not zero");
	property p_rx_out; p3PinOe[1] && $past(p3PinOe[1]) |-> serial0RxData; endproperty
	a_rx_out: assert property (p_rx_out) else $error("receive feed not idle");
	property p_reset; $rose(resetn) |-> p2PinOe == 8'h00 && p3PinOe == 8'h00; endproperty
	a_reset: assert property (p_reset) else $error("pins driven after reset");
	c_bit: cover property (bitWrite && bitAddr[7:3] == 5'h16);
	c_spi: cover property (spiEnable && p2PinOe == 8'h4f);
	c_miss: cover property (sfrRead && !sfrHit);
endmodule // port_pin_monitor
bind port_pin_config_and_data port_pin_monitor #(.NARROW_W(NARROW_W), .WIDE_W(WIDE_W)) u_port_pin_monitor (
	.clk, .resetn, .sfrAddr, .sfrWrite, .sfrRead, .sfrWrData, .sfrRdData, .sfrHit, .bitAddr, .bitWrite,
	.bitWrData, .p2PinOut, .p2PinOe, .p3PinOut, .p3PinOe, .spiEnable, .twoWireEnable, .serial0Enable,
	.serial0RxData);
`default_nettype wire

// ==== verif/gpio_pin_partner.sv ====
// Model of the external devices on one port's pins.
// Assumes the device drives every pin the block leaves undriven, so no level is left floating.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_partner #(
	parameter W = 8
) (
	input wire logic [W-1:0] pinOut,
	input wire logic [W-1:0] pinOe,
	input wire logic [W-1:0] extVal,
	output logic [W-1:0] pinIn
);
	assign pinIn = (pinOut & pinOe) | (extVal & ~pinOe);
endmodule // gpio_pin_partner
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the four-port pin block with pin models on every port.
// Assumes the block's register map header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_map.vh"
module tb;
	logic clk = '0, resetn = '0, sfrWrite = '0, sfrRead = '0, bitWrite = '0, bitRead = '0, bitWrData = '0;
	logic spiEnable = '0, spiDataOut = '0, twoWireEnable = '0, twoWireClockOut = '0, twoWireDataOut = '0;
	logic timerEnableA = 1'h1, timerEnableB = 1'h1, serial0Enable = '0, serial0TxData = '0;
	logic [7:0] sfrAddr = '0, sfrWrData = '0, bitAddr = '0, ext3 = 8'h69, got, sfrRdData;
	logic [7:0] p2PinIn, p2PinOut, p2PinOe, p3PinIn, p3PinOut, p3PinOe;
	logic [3:0] port0OutSel = 4'h5, port1OutSel = 4'ha, spiChipSel = '0;
	logic [3:0] p0PinIn, p0PinOut, p0PinOe, p1PinIn, p1PinOut, p1PinOe;
	logic sfrHit, bitHit, bitRdData, spiDataIn, spiClockIn, spiSlaveSelIn, timerCountA, timerCountB;
	logic captureInputA, captureInputB, serial0RxData;
	int mismatches = 0, n_tests = 0, cycles = 0;
	// Rows: address, write data, expected read back.
	logic [23:0] rows [11] = '{24'h9dffff, 24'h9effff, 24'ha05a5a, 24'hb0c3c3, 24'h80ff05, 24'h90a302,
		24'h9d0000, 24'ha0ff96, 24'h9e0f0f, 24'hb00060, 24'h555500};
	port_pin_config_and_data u_port_pin_config_and_data (.clk, .resetn, .sfrAddr, .sfrWrite, .sfrRead,
		.sfrWrData, .sfrRdData, .sfrHit, .bitAddr, .bitWrite, .bitRead, .bitWrData, .bitRdData, .bitHit,
		.port0OutSel, .port1OutSel, .p0PinIn, .p0PinOut, .p0PinOe, .p1PinIn, .p1PinOut, .p1PinOe, .p2PinIn,
		.p2PinOut, .p2PinOe, .p3PinIn, .p3PinOut, .p3PinOe, .spiEnable, .spiDataOut, .spiChipSel, .spiDataIn,
		.spiClockIn, .spiSlaveSelIn, .twoWireEnable, .twoWireClockOut, .twoWireDataOut, .timerEnableA,
		.timerEnableB, .timerCountA, .timerCountB, .captureInputA, .captureInputB, .serial0Enable,
		.serial0TxData, .serial0RxData);
	gpio_pin_partner #(.W(4)) u_gpio_pin_partner_p0 (.pinOut(p0PinOut), .pinOe(p0PinOe), .extVal(4'h0), .pinIn(p0PinIn));
	gpio_pin_partner #(.W(4)) u_gpio_pin_partner_p1 (.pinOut(p1PinOut), .pinOe(p1PinOe), .extVal(4'h0), .pinIn(p1PinIn));
	gpio_pin_partner u_gpio_pin_partner_p2 (.pinOut(p2PinOut), .pinOe(p2PinOe), .extVal(8'h96), .pinIn(p2PinIn));
	gpio_pin_partner u_gpio_pin_partner_p3 (.pinOut(p3PinOut), .pinOe(p3PinOe), .extVal(ext3), .pinIn(p3PinIn));
	always #4 clk = ~clk;
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Strobes drop for a full cycle so back-to-back calls never reassign them in one step.
	task automatic wr(logic [7:0] a, logic [7:0] d);
		sfrAddr = a;
		sfrWrData = d;
		sfrWrite = 1'h1;
		tick(1);
		sfrWrite = 1'h0;
		tick(1);
	endtask
	task automatic rd(logic [7:0] a);
		sfrAddr = a;
		sfrRead = 1'h1;
		tick(1);
		got = sfrRdData;
		sfrRead = 1'h0;
		tick(1);
	endtask
	task automatic bw(logic [7:0] a, logic v);
		bitAddr = a;
		bitWrData = v;
		bitWrite = 1'h1;
		tick(1);
		bitWrite = 1'h0;
		tick(1);
	endtask
	task automatic br(logic [7:0] a);
		bitAddr = a;
		bitRead = 1'h1;
		tick(1);
		got = {7'h0, bitRdData};
		bitRead = 1'h0;
		tick(1);
	endtask
	task automatic cmp(logic [7:0] g, logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic end_sim;
		$display("Comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			end_sim();
		end
	end
	initial begin
		tick(10);
		cmp(p2PinOe | p3PinOe, 8'h00);
		resetn = 1'h1;
		tick(2);
		rd(`ADDR_PORT3_CFG);
		cmp(got, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			tick(3);
			rd(rows[i][23:16]);
			cmp(got, rows[i][7:0]);
		end
		cmp({p0PinOe, p0PinOut}, 8'h5f);
		cmp({p1PinOe, p1PinOut}, 8'ha3);
		wr(`ADDR_PORT3_CFG, 8'hff);
		wr(`ADDR_PORT3_DATA, 8'h5a);
		bw(8'hb0, 1'h1);
		tick(3);
		cmp(p3PinOe, 8'hff);
		cmp(p3PinOut, 8'h5b);
		br(8'hb1);
		cmp(got, 8'h01);
		cmp({7'h0, bitHit}, 8'h01);
		br(8'h55);
		cmp({6'h0, bitHit, got[0]}, 8'h00);
		cmp({3'h0, timerCountB, captureInputB, captureInputA, timerCountA, serial0RxData}, 8'h1f);
		{twoWireEnable, twoWireClockOut, serial0Enable} = 3'h7;
		tick(3);
		cmp(p3PinOut, 8'h9a);
		wr(`ADDR_PORT3_CFG, 8'h00);
		ext3 = 8'h00;
		tick(4);
		cmp({3'h0, timerCountB, captureInputB, captureInputA, timerCountA, serial0RxData}, 8'h00);
		cmp(p3PinOe, 8'h00);
		{timerEnableA, timerEnableB} = 2'h0;
		tick(2);
		cmp({3'h0, timerCountB, captureInputB, captureInputA, timerCountA, serial0RxData}, 8'h12);
		{spiEnable, spiChipSel} = 5'h1e;
		wr(`ADDR_PORT2_CFG, 8'h4f);
		tick(3);
		cmp(p2PinOe, 8'h4f);
		cmp({3'h0, p2PinOut[6], p2PinOut[3:0]}, 8'h07);
		cmp({5'h0, spiDataIn, spiClockIn, spiSlaveSelIn}, 8'h05);
		wr(`ADDR_PORT2_CFG, 8'hb0);
		tick(3);
		cmp({5'h0, spiDataIn, spiClockIn, spiSlaveSelIn}, 8'h07);
		resetn = 1'h0;
		tick(2);
		cmp(p2PinOe | p3PinOe, 8'h00);
		resetn = 1'h1;
		tick(2);
		rd(`ADDR_PORT2_CFG);
		cmp(got, 8'h00);
		end_sim();
	end
endmodule // tb
`default_nettype wire
